// File: core/dimming_defines.svh
// shared constants for the single-wire dimming link
// assumes a 100 MHz ref_clk on both ends
`ifndef DIMMING_DEFINES_SVH
`define DIMMING_DEFINES_SVH
`define CLK_MHZ 100
`define CODE_W 5
`define ONE_MIN_US 15
`define ONE_MAX_US 45
`define ZERO_MIN_US 90
`define ZERO_MAX_US 120
`define LOAD_MIN_US 215
`define HIGH_MIN_US 3
// least times round up, longest round down; 100 MHz makes both exact
`define ONE_MIN_CYC (`ONE_MIN_US * `CLK_MHZ)
`define ONE_MAX_CYC (`ONE_MAX_US * `CLK_MHZ)
`define ZERO_MIN_CYC (`ZERO_MIN_US * `CLK_MHZ)
`define ZERO_MAX_CYC (`ZERO_MAX_US * `CLK_MHZ)
`define LOAD_MIN_CYC (`LOAD_MIN_US * `CLK_MHZ)
`define HIGH_MIN_CYC (`HIGH_MIN_US * `CLK_MHZ)
// host sends widths inside the windows
`define ONE_SEND_CYC (30 * `CLK_MHZ)
`define ZERO_SEND_CYC (105 * `CLK_MHZ)
`define LOAD_SEND_CYC (250 * `CLK_MHZ)
`define GAP_SEND_CYC (5 * `CLK_MHZ)
// reference in microvolts: 9800 + 5680 * code
`define VREF_BASE_UV 9800
`define VREF_STEP_UV 5680
`define OVP_HYST_PCT 7
`define PCT_FULL 100
`define OVP_14V_MV 14000
`define OVP_18V_MV 18000
`define OVP_26V_MV 26000
// line idles high, enable resets low, lockout resets high
`define SYNC_RST 3'h5
// code 31 gives 185880 uV, so 16 bits would wrap
`define VREF_W 18
`endif

// File: core/dimming_pkg.sv
// types used by the device end of the dimming link
// no assumptions beyond the defines header
package dimming_pkg;
  typedef enum logic [1:0] {sym_one, sym_zero, sym_load} sym_t;
  typedef enum logic [1:0] {ovp_14v, ovp_18v, ovp_26v} ovp_opt_t;
endpackage

// File: core/dimming_link_if.sv
// open-drain dimming line joining host and device
// the pull-up is modelled here; ends only drive low
`timescale 1ns/1ps
interface dimming_link_if;
  logic host_oe;
  logic dev_oe;
  logic dimming_serial_line;
  assign dimming_serial_line = ~(host_oe | dev_oe);
  modport device (input dimming_serial_line, output dev_oe);
  modport host (input dimming_serial_line, output host_oe);
endinterface

// File: core/dimming_device.sv
// device end: pulse-width receiver, brightness register, ovp control
// assumes the line comes from another domain; one 100 MHz clock
`timescale 1ns/1ps
`include "dimming_defines.svh"
module dimming_device #(
  parameter dimming_pkg::ovp_opt_t ovp_option = dimming_pkg::ovp_18v,
  parameter int unsigned cnt_w = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  dimming_link_if.device link,
  input wire logic enable,
  input wire logic undervoltage_lockout,
  input wire logic [15:0] boost_output_mv,
  output logic [`CODE_W-1:0] brightness_q,
  output logic [`VREF_W-1:0] vref_uv_q,
  output logic switch_enable_q,
  output logic feedback_disconnect_switch_q,
  output logic powered_q
);
  localparam int unsigned sync_n = 3;
  localparam logic [sync_n-1:0] sync_rst = `SYNC_RST;
  localparam int unsigned vref_w = `VREF_W;
  // bit 0 line, bit 1 enable, bit 2 lockout
  logic [sync_n-1:0] sync_in;
  logic [sync_n-1:0] sync_s1_q;
  logic [sync_n-1:0] sync_s2_q;
  logic line_s2;
  logic en_s2;
  logic uv_s2;
  logic line_prev_q;
  logic [cnt_w-1:0] low_cnt_q;
  logic [`CODE_W-1:0] shift_q;
  logic ovp_trip_q;
  logic active;
  logic rise;
  dimming_pkg::sym_t sym;
  logic sym_ok;
  logic [15:0] ovp_mv;
  logic [15:0] ovp_low_mv;

  // threshold is fixed per variant; no run-time select
  function automatic logic [15:0] ovp_thresh(dimming_pkg::ovp_opt_t o);
    unique case (o)
      dimming_pkg::ovp_14v: ovp_thresh = 16'(`OVP_14V_MV);
      dimming_pkg::ovp_18v: ovp_thresh = 16'(`OVP_18V_MV);
      default: ovp_thresh = 16'(`OVP_26V_MV);
    endcase
  endfunction

  // used for both bit windows; both ends inclusive
  function automatic logic in_window(logic [cnt_w-1:0] n,
                                     logic [cnt_w-1:0] lo,
                                     logic [cnt_w-1:0] hi);
    in_window = (n >= lo) && (n <= hi);
  endfunction

  assign ovp_mv = ovp_thresh(ovp_option);
  // hysteresis floor in whole mV, rounded down
  assign ovp_low_mv = 16'((32'(ovp_mv) *
    (32'(`PCT_FULL) - 32'(`OVP_HYST_PCT))) / 32'(`PCT_FULL));
  assign sync_in = {undervoltage_lockout, enable, link.dimming_serial_line};
  assign line_s2 = sync_s2_q[0];
  assign en_s2 = sync_s2_q[1];
  assign uv_s2 = sync_s2_q[2];
  assign active = en_s2 & ~uv_s2;
  assign rise = line_s2 & ~line_prev_q;

  // never drive the line; the device only listens
  assign link.dev_oe = 1'b0;

  // two flops on the line, enable and lockout inputs before any logic reads them
  for (genvar g = 0; g < sync_n; g++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        sync_s1_q[g] <= sync_rst[g];
        sync_s2_q[g] <= sync_rst[g];
      end else begin
        sync_s1_q[g] <= sync_in[g];
        sync_s2_q[g] <= sync_s1_q[g];
      end
    end
  end

  // idle-high reset value keeps reset release from faking a rise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_prev_q <= 1'b1;
    end else begin
      line_prev_q <= line_s2;
    end
  end

  // saturating low-time counter; restarts on every rising edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= '0;
    end else if (!active || line_s2) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != '1) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  // classify the finished low time; anything else stays unmatched
  always_comb begin
    sym = dimming_pkg::sym_load;
    sym_ok = 1'b0;
    if (in_window(low_cnt_q, cnt_w'(`ONE_MIN_CYC),
                  cnt_w'(`ONE_MAX_CYC))) begin
      sym = dimming_pkg::sym_one;
      sym_ok = 1'b1;
    end else if (in_window(low_cnt_q, cnt_w'(`ZERO_MIN_CYC),
                           cnt_w'(`ZERO_MAX_CYC))) begin
      sym = dimming_pkg::sym_zero;
      sym_ok = 1'b1;
    end else if (low_cnt_q > cnt_w'(`LOAD_MIN_CYC)) begin
      sym = dimming_pkg::sym_load;
      sym_ok = 1'b1;
    end
  end

  // widths are judged at the rising edge so a load fires once
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= '0;
      brightness_q <= '0;
    end else if (!active) begin
      shift_q <= '0;
      brightness_q <= '0;
    end else if (rise && sym_ok) begin
      unique case (sym)
        dimming_pkg::sym_one: begin
          shift_q <= {shift_q[`CODE_W-2:0], 1'b1};
        end
        dimming_pkg::sym_zero: begin
          shift_q <= {shift_q[`CODE_W-2:0], 1'b0};
        end
        dimming_pkg::sym_load: begin
          brightness_q <= shift_q;
        end
      endcase
    end
    // other widths never reach the register
  end

  // reference follows the code a cycle later
  // width covers the top code with no wrap
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vref_uv_q <= vref_w'(`VREF_BASE_UV);
    end else begin
      vref_uv_q <= vref_w'(`VREF_BASE_UV +
        `VREF_STEP_UV * 32'(brightness_q));
    end
  end

  // hysteresis: trip at threshold, clear 7 percent below; code untouched
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovp_trip_q <= 1'b0;
    end else if (boost_output_mv >= ovp_mv) begin
      ovp_trip_q <= 1'b1;
    end else if (boost_output_mv < ovp_low_mv) begin
      ovp_trip_q <= 1'b0;
    end
  end

  // switching pauses in ovp but the code and power state stay
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_enable_q <= 1'b0;
    end else begin
      switch_enable_q <= active & ~ovp_trip_q;
    end
  end

  // opening the switch on disable isolates a shorted string
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      feedback_disconnect_switch_q <= 1'b0;
      powered_q <= 1'b0;
    end else begin
      feedback_disconnect_switch_q <= active;
      powered_q <= active;
    end
  end
endmodule

// File: core/dimming_host.sv
// host end: sends a code msb first then a load pulse
// assumes the device samples widths on its own clock
// only drives low; pull-up lives in the interface
`timescale 1ns/1ps
`include "dimming_defines.svh"
module dimming_host #(
  parameter int unsigned cnt_w = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  dimming_link_if.host link,
  input wire logic send_req,
  input wire logic [`CODE_W-1:0] send_code,
  output logic busy_q,
  output logic done_q
);
  typedef enum logic [1:0] {st_idle, st_low, st_gap} state_t;
  state_t state_q;
  logic [cnt_w-1:0] cnt_q;
  logic [`CODE_W-1:0] code_q;
  logic [2:0] bit_q;
  logic oe_q;

  function automatic logic [cnt_w-1:0] width_of(logic [2:0] b,
                                                 logic [`CODE_W-1:0] c);
    if (b == 3'(`CODE_W)) begin
      width_of = cnt_w'(`LOAD_SEND_CYC);
    end else if (c[3'(`CODE_W - 1) - b]) begin
      width_of = cnt_w'(`ONE_SEND_CYC);
    end else begin
      width_of = cnt_w'(`ZERO_SEND_CYC);
    end
  endfunction

  assign link.host_oe = oe_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= st_idle;
      cnt_q <= '0;
      code_q <= '0;
      bit_q <= '0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        st_idle: begin
          if (send_req) begin
            code_q <= send_code;
            bit_q <= '0;
            cnt_q <= width_of(3'd0, send_code) - 1'b1;
            oe_q <= 1'b1;
            busy_q <= 1'b1;
            state_q <= st_low;
          end
        end
        st_low: begin
          if (cnt_q == '0) begin
            oe_q <= 1'b0;
            cnt_q <= cnt_w'(`GAP_SEND_CYC) - 1'b1;
            state_q <= st_gap;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        st_gap: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (bit_q == 3'(`CODE_W)) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= st_idle;
          end else begin
            bit_q <= bit_q + 1'b1;
            cnt_q <= width_of(bit_q + 1'b1, code_q) - 1'b1;
            oe_q <= 1'b1;
            state_q <= st_low;
          end
        end
      endcase
    end
  end
endmodule

// File: testbench/dimming_link_properties.sv
// checker for the link and device one
// assumes one ref_clk for host and device
`timescale 1ns/1ps
`include "dimming_defines.svh"
module dimming_link_properties #(
  parameter int thr_mv = 18000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic busy_q,
  input wire logic enable,
  input wire logic undervoltage_lockout,
  input wire logic [15:0] boost_output_mv,
  input wire logic [4:0] brightness_q,
  input wire logic [`VREF_W-1:0] vref_uv_q,
  input wire logic switch_enable_q
);
  logic [15:0] low_q;
  logic [15:0] high_q;
  logic [15:0] last_q;
  // high count saturates so long idle never wraps
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_q <= '0;
      high_q <= '1;
      last_q <= '0;
    end else begin
      low_q <= host_oe ? low_q + 16'h1 : 16'h0;
      high_q <= host_oe ? 16'h0 : (&high_q ? high_q : high_q + 16'h1);
      if (host_oe) last_q <= low_q + 16'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_off; !enable [*4]; endsequence
  sequence s_lock; undervoltage_lockout [*4]; endsequence
  property p_quiet; !dev_oe; endproperty
  property p_idle; !busy_q |-> !host_oe; endproperty
  property p_gap; $rose(host_oe) |-> high_q >= `HIGH_MIN_CYC; endproperty
  property p_width;
    $fell(host_oe) |-> low_q inside {[`ONE_MIN_CYC:`ONE_MAX_CYC],
      [`ZERO_MIN_CYC:`ZERO_MAX_CYC]} || low_q > `LOAD_MIN_CYC;
  endproperty
  property p_vref;
    32'(vref_uv_q) == `VREF_BASE_UV + `VREF_STEP_UV * $past(brightness_q);
  endproperty
  property p_load;
    $changed(brightness_q) && brightness_q != 0 |-> last_q > `LOAD_MIN_CYC;
  endproperty
  property p_off; s_off |=> brightness_q == 0; endproperty
  property p_lock; s_lock |=> brightness_q == 0; endproperty
  // trip flop then output flop: two edges after the sample
  property p_ovp;
    boost_output_mv >= thr_mv |-> ##2 !switch_enable_q;
  endproperty
  a_quiet: assert property (p_quiet) else $error("device drove line");
  a_idle: assert property (p_idle) else $error("line low while idle");
  a_gap: assert property (p_gap) else $error("high gap too short");
  a_width: assert property (p_width) else $error("bad pulse width");
  a_vref: assert property (p_vref) else $error("reference wrong");
  a_load: assert property (p_load) else $error("code without load");
  a_off: assert property (p_off) else $error("code kept on disable");
  a_lock: assert property (p_lock) else $error("code kept in lockout");
  a_ovp: assert property (p_ovp) else $error("switching in ovp");
endmodule

// File: testbench/test_pulse_width_dimming_receiver.sv
// bench: host to device one, raw pulses to device two
// assumes 100 MHz ref_clk and both ends as built
`timescale 1ns/1ps
`include "dimming_defines.svh"
module test_pulse_width_dimming_receiver;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req = 1'b0;
  logic drv = 1'b0;
  logic en_a = 1'b1, uv_a = 1'b0, uv_b = 1'b0;
  logic [4:0] code = 5'h00;
  logic [15:0] mv = 16'h0000;
  logic busy_q, done_q, se_a, pw_a, fb_a;
  logic [4:0] br_a, br_b;
  logic [`VREF_W-1:0] vr_a;
  int err_total = 0, tests_run = 0, seed = 85165, exp;
  int q[$];
  int w[8] = '{1500, 9000, 1499, 4500, 4501, 12000, 9000, 21501};
  dimming_link_if lk();
  dimming_link_if lk2();
  assign lk2.host_oe = drv;
  initial forever #5 ref_clk = ~ref_clk;
  dimming_host dimming_host_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(lk.host), .send_req(req), .send_code(code), .busy_q(busy_q),
    .done_q(done_q));
  dimming_device dimming_device_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(lk.device), .enable(en_a), .undervoltage_lockout(uv_a),
    .boost_output_mv(mv), .brightness_q(br_a), .vref_uv_q(vr_a),
    .switch_enable_q(se_a), .feedback_disconnect_switch_q(fb_a),
    .powered_q(pw_a));
  dimming_device dimming_device_i2 (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(lk2.device), .enable(1'b1), .undervoltage_lockout(uv_b),
    .boost_output_mv(mv), .brightness_q(br_b), .vref_uv_q(),
    .switch_enable_q(), .feedback_disconnect_switch_q(), .powered_q());
  dimming_link_properties dimming_link_properties_i (.ref_clk(ref_clk),
    .rst_b(rst_b), .host_oe(lk.host_oe), .dev_oe(lk.dev_oe),
    .busy_q(busy_q), .enable(en_a), .undervoltage_lockout(uv_a),
    .boost_output_mv(mv), .brightness_q(br_a), .vref_uv_q(vr_a),
    .switch_enable_q(se_a));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // raw pulse plus model: windows inclusive, load strictly longer
  task automatic pulse(input int n);
    drv = 1'b1;
    wt(n);
    drv = 1'b0;
    if (n >= `ONE_MIN_CYC && n <= `ONE_MAX_CYC) q.push_back(1);
    else if (n >= `ZERO_MIN_CYC && n <= `ZERO_MAX_CYC) q.push_back(0);
    else if (n > `LOAD_MIN_CYC) begin
      exp = 0;
      foreach (q[i]) exp = ((exp << 1) | q[i]) & 31;
    end
    wt(500);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // longest path: four zeros, a one, then load, about 73000 cycles
  initial begin
    #1000000;
    err_total++;
    $display("[ERR] %0t timeout", $time);
    tally_and_finish();
  end
  initial begin
    wt(3);
    rst_b = 1'b1;
    chk(br_a === 5'h00 && vr_a === 18'h02648, "power-up code");
    fork
      begin
        code = 5'($random(seed)) | 5'h01; // nonzero so a clear shows
        req = 1'b1;
        wt(1);
        req = 1'b0;
        chk(busy_q === 1'b1 && lk.host_oe === 1'b1, "host start");
        for (int i = 0; i < 90000 && done_q !== 1'b1; i++) wt(1);
        chk(done_q === 1'b1 && busy_q === 1'b0, "host done");
        wt(10);
        chk(br_a === code, "host code");
        chk(32'(vr_a) === 9800 + 5680 * code, "reference");
        mv = 16'h4650;
        wt(3);
        chk(se_a === 1'b0 && br_a === code && pw_a === 1'b1,
          "ovp halt");
        mv = 16'h41a0;
        wt(3);
        chk(se_a === 1'b0, "ovp hysteresis");
        mv = 16'h4163;
        wt(5);
        chk(se_a === 1'b1, "ovp resume");
        en_a = 1'b0; // one long low, never a pwm
        wt(6);
        chk(br_a === 5'h00 && pw_a === 1'b0, "disable");
        chk(fb_a === 1'b0, "switch open");
        en_a = 1'b1;
        uv_a = 1'b1;
        wt(6);
        chk(br_a === 5'h00 && pw_a === 1'b0, "lockout clear");
        uv_a = 1'b0;
        $display("host path test done");
      end
      begin
        foreach (w[i]) pulse(w[i]);
        wt(10);
        chk(br_b === 5'(exp), "raw load");
        uv_b = 1'b1;
        wt(6);
        chk(br_b === 5'h00, "lockout clear two");
        uv_b = 1'b0;
        $display("raw pulse test done");
      end
    join
    tally_and_finish();
  end
endmodule
